/* pes_sequencer.sv */
// exception sequencer: request latching, status update, frame, vector
//
// Added by the designer: the register addresses and strobed register access.
`timescale 1ns/10ps
// Function
// - latch interrupts, bus error, reset requests (interrupts are not latched here; ipl is sampled live while idle)
// - trapping instructions raise exceptions when conditioned
// - illegal, odd fetch, privilege raise exceptions
// - trace ranks as very high interrupt
// - snapshot status before changing it
// - set supervisor flag
// - clear both trace mode bits
// - reset and interrupt update priority mask
// - interrupt vector from acknowledge read
// - coprocessor supplies its vector number
// - other vectors come from internal logic
// - push frame sized by exception type
// - master stack used when select set
// - interrupt under master: clear, throwaway frame
// - reset clears select, no frame
// - vector offset is number times four (fetch address only; the frame offset field holds vec_r[5:0] times 64)
// - vector address adds table base
// - load new program counter from vector
module pes_sequencer
   import pes_pkg::*;
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        nrst,
   // register port
   input  wire logic [7:0]  regAddr,
   input  wire logic [31:0] regWdata,
   input  wire logic        regWr,
   input  wire logic        regRd,
   output logic      [31:0] regRdata,
   // exception sources
   input  wire logic        rstExc,
   input  wire logic        busErr,
   input  wire logic [31:0] faultAddr,
   input  wire logic        oddFetch,
   input  wire logic        traceReq,
   input  wire logic        illegalOp,
   input  wire logic        privViol,
   input  wire logic [2:0]  ipl,
   input  pes_instr_s       instrExc,
   input  wire logic        cpExc,
   input  wire logic [7:0]  cpVec,
   input  wire logic [31:0] curPc,
   // memory cycles
   output pes_mem_s         memQ,
   input  wire logic        memAck,
   input  wire logic [31:0] memRdata,
   // core side
   output logic      [15:0] srOut,
   output logic             pcLoad,
   output logic      [31:0] newPc,
   output logic             busy,
   output logic             irq
);
   pes_state_e        st_r;
   pes_mem_s          memQ_r;
   logic [P_W-1:0]    pend_r;
   logic [P_W-1:0]    pendSet;
   logic [P_W-1:0]    pendClr;
   logic [15:0]       sr_r;
   logic [15:0]       srCopy_r;
   logic [31:0]       vbase_r;
   logic [31:0]       msp_r;
   logic [31:0]       isp_r;
   logic [31:0]       pcSave_r;
   logic [31:0]       fault_r;
   logic [31:0]       newPc_r;
   logic [31:0]       rdata_r;
   logic [31:0]       spSel;
   logic [31:0]       frameWord;
   logic [7:0]        vec_r;
   logic [7:0]        insVec_r;
   logic [7:0]        cpVec_r;
   logic [7:0]        selVec;
   logic [2:0]        lvl_r;
   logic [1:0]        idx_r;
   logic [ST_W-1:0]   stat_r;
   logic [ST_W-1:0]   mask_r;
   logic [ST_W-1:0]   evt;
   logic              kRst_r;
   logic              kInt_r;
   logic              longFr_r;
   logic              throw_r;
   logic              onMsp_r;
   logic              intOk;
   logic              take;
   logic              selInt;
   logic              selLong;
   logic              insRaise;
   logic              ack;
   logic              lastLong;
   logic              pushing;

   // internal vector of a trapping instruction
   function automatic logic [7:0] instrVec(pes_ikind_e k, logic [3:0] n);
      logic [7:0] v;
      v = VEC_CTRAP;
      unique case (k)
         IK_TRAP:        v = VEC_SWBASE + {4'h0, n};
         IK_BND, IK_BND2: v = VEC_BOUNDS;
         IK_DIV:         v = VEC_ZERODIV;
         default:        v = VEC_CTRAP;
      endcase
      return v;
   endfunction

   assign ack      = memQ_r.req && memAck;
   assign lastLong = (idx_r == 2'h0);
   assign pushing  = (st_r == S_PUSH) && ack;

   // unconditional vector call or condition met
   assign insRaise = instrExc.valid &&
                     (instrExc.kind == IK_TRAP || instrExc.cond);

   always_comb begin
      pendSet         = '0;
      pendSet[P_RST]  = rstExc;
      pendSet[P_BERR] = busErr;
      pendSet[P_ODD]  = oddFetch;
      pendSet[P_ILL]  = illegalOp;
      pendSet[P_PRV]  = privViol;
      pendSet[P_TRC]  = traceReq;
      pendSet[P_INS]  = insRaise;
      pendSet[P_CP]   = cpExc;
   end

   // interrupt accepted above mask, top level always
   assign intOk = (ipl > sr_r[SR_IPM +: 3]) || (ipl == IPM_MAX);

   // trace ahead of interrupts, fixed priority scan
   always_comb begin
      pendClr = '0;
      selVec  = VEC_RESET;
      selInt  = 1'b0;
      selLong = 1'b0;
      take    = 1'b1;
      if (pend_r[P_RST]) begin
         pendClr[P_RST] = 1'b1;
      end else if (pend_r[P_BERR]) begin
         pendClr[P_BERR] = 1'b1;
         selVec  = VEC_BUSERR;
         selLong = 1'b1;
      end else if (pend_r[P_ODD]) begin
         pendClr[P_ODD] = 1'b1;
         selVec  = VEC_ADDRERR;
         selLong = 1'b1;
      end else if (pend_r[P_TRC]) begin
         pendClr[P_TRC] = 1'b1;
         selVec  = VEC_TRACE;
      end else if (intOk) begin
         selInt = 1'b1;
      end else if (pend_r[P_ILL]) begin
         pendClr[P_ILL] = 1'b1;
         selVec  = VEC_ILLEGAL;
      end else if (pend_r[P_PRV]) begin
         pendClr[P_PRV] = 1'b1;
         selVec  = VEC_PRIV;
      end else if (pend_r[P_INS]) begin
         pendClr[P_INS] = 1'b1;
         selVec  = insVec_r;
      end else if (pend_r[P_CP]) begin
         pendClr[P_CP] = 1'b1;
         selVec  = cpVec_r;
      end else begin
         take = 1'b0;
      end
      if (st_r != S_IDLE) begin
         take    = 1'b0;
         pendClr = '0;
      end
   end

   // set wins so a request landing on its own clear survives
   always_ff @(posedge clk) begin
      if (!nrst) begin
         pend_r   <= '0;
         insVec_r <= 8'h00;
         cpVec_r  <= 8'h00;
      end else begin
         pend_r <= (pend_r & ~pendClr) | pendSet;
         if (insRaise)
            insVec_r <= instrVec(instrExc.kind, instrExc.trapNum);
         if (cpExc)
            cpVec_r <= cpVec;
      end
   end

   // sequence control
   always_ff @(posedge clk) begin
      if (!nrst) begin
         st_r     <= S_IDLE;
         kRst_r   <= 1'b0;
         kInt_r   <= 1'b0;
         longFr_r <= 1'b0;
         throw_r  <= 1'b0;
         onMsp_r  <= 1'b0;
         vec_r    <= 8'h00;
         lvl_r    <= 3'h0;
         idx_r    <= 2'h0;
         pcSave_r <= '0;
         fault_r  <= '0;
         newPc_r  <= '0;
      end else begin
         unique case (st_r)
            S_IDLE: if (take) begin
               kRst_r   <= pend_r[P_RST];
               kInt_r   <= selInt;
               longFr_r <= selLong;
               vec_r    <= selVec;
               lvl_r    <= pend_r[P_RST] ? IPM_MAX : ipl;
               pcSave_r <= curPc;
               fault_r  <= faultAddr;
               st_r     <= S_CAPT;
            end
            S_CAPT: begin
               idx_r <= longFr_r ? IDX_FAULT : IDX_SHORT;
               // task exceptions follow the select bit
               onMsp_r <= sr_r[SR_M];
               // a second frame follows on the interrupt stack
               throw_r <= kInt_r && sr_r[SR_M];
               if (kRst_r)
                  st_r <= S_VEC;
               else if (kInt_r)
                  st_r <= S_IACK;
               else
                  st_r <= S_PUSH;
            end
            S_IACK: if (ack) begin
               vec_r <= memRdata[7:0];
               st_r  <= S_PUSH;
            end
            S_PUSH: if (ack) begin
               if (!lastLong)
                  idx_r <= idx_r - 2'h1;
               else if (throw_r) begin
                  throw_r <= 1'b0;
                  onMsp_r <= 1'b0;
                  idx_r   <= IDX_SHORT;
               end else
                  st_r <= S_VEC;
            end
            S_VEC: if (ack) begin
               newPc_r <= memRdata;
               st_r    <= S_DONE;
            end
            S_DONE: st_r <= S_IDLE;
         endcase
      end
   end

   // status register and its snapshot
   always_ff @(posedge clk) begin
      if (!nrst) begin
         sr_r     <= SR_RST;
         srCopy_r <= SR_RST;
      end else if (st_r == S_CAPT) begin
         srCopy_r <= sr_r;
         sr_r[SR_S] <= 1'b1;
         sr_r[SR_T1] <= 1'b0;
         sr_r[SR_T0] <= 1'b0;
         if (kRst_r || kInt_r)
            sr_r[SR_IPM +: 3] <= lvl_r;
         if (kRst_r)
            sr_r[SR_M] <= 1'b0;
      end else if (pushing && lastLong && throw_r) begin
         // select bit off after the master frame
         sr_r[SR_M] <= 1'b0;
      end else if (regWr && regAddr == REG_SR && st_r == S_IDLE) begin
         sr_r <= regWdata[15:0];
      end
   end

   // stack pointers; software writes ignored mid-sequence
   assign spSel = onMsp_r ? msp_r : isp_r;

   always_ff @(posedge clk) begin
      if (!nrst) begin
         msp_r   <= '0;
         isp_r   <= '0;
         vbase_r <= '0;
      end else if (pushing) begin
         if (onMsp_r)
            msp_r <= msp_r - LONG_BYTES;
         else
            isp_r <= isp_r - LONG_BYTES;
      end else if (regWr && st_r == S_IDLE) begin
         if (regAddr == REG_MSP)
            msp_r <= regWdata;
         if (regAddr == REG_ISP)
            isp_r <= regWdata;
         if (regAddr == REG_VBASE)
            vbase_r <= regWdata;
      end
   end

   // frame longs, highest index pushed first
   always_comb begin
      frameWord = {pcSave_r[15:0], FMT_SHORT, vec_r, 4'h0};
      unique case (idx_r)
         2'h0: frameWord = {srCopy_r, pcSave_r[31:16]};
         // master frame points on to the interrupt stack
         2'h1: frameWord = {pcSave_r[15:0],
                            throw_r ? FMT_THROW :
                            longFr_r ? FMT_FAULT : FMT_SHORT,
                            vec_r[5:0], 6'h00};
         2'h2: frameWord = fault_r;
         2'h3: frameWord = pcSave_r;
      endcase
   end

   // one memory cycle at a time, a new one per frame long in push, dropped on acknowledge
   always_ff @(posedge clk) begin
      if (!nrst) begin
         memQ_r <= '0;
      end else if (ack) begin
         memQ_r.req <= 1'b0;
      end else if (!memQ_r.req) begin
         memQ_r.req   <= (st_r == S_IACK) || (st_r == S_PUSH) ||
                         (st_r == S_VEC);
         memQ_r.wr    <= (st_r == S_PUSH);
         memQ_r.iack  <= (st_r == S_IACK);
         memQ_r.wdata <= frameWord;
         if (st_r == S_IACK)
            memQ_r.addr <= {29'h0, lvl_r};
         else if (st_r == S_PUSH)
            memQ_r.addr <= spSel - LONG_BYTES;
         else
            memQ_r.addr <= vbase_r + (32'(vec_r) << VEC_SHIFT);
      end
   end

   // sticky events, cleared by reading the status word
   always_comb begin
      evt          = '0;
      evt[ST_DONE] = (st_r == S_DONE);
      evt[ST_BERR] = (st_r == S_CAPT) && longFr_r;
      evt[ST_INT]  = (st_r == S_CAPT) && kInt_r;
      evt[ST_RST]  = (st_r == S_CAPT) && kRst_r;
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         stat_r <= '0;
         mask_r <= '0;
      end else begin
         stat_r <= (regRd && regAddr == REG_STAT) ? evt : (stat_r | evt);
         if (regWr && regAddr == REG_MASK)
            mask_r <= regWdata[ST_W-1:0];
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         rdata_r <= '0;
      end else if (regRd) begin
         unique case (regAddr)
            REG_VBASE: rdata_r <= vbase_r;
            REG_MSP:   rdata_r <= msp_r;
            REG_ISP:   rdata_r <= isp_r;
            REG_SR:    rdata_r <= {16'h0, sr_r};
            REG_STAT:  rdata_r <= {28'h0, stat_r};
            REG_MASK:  rdata_r <= {28'h0, mask_r};
            REG_NEWPC: rdata_r <= newPc_r;
            REG_VEC:   rdata_r <= {24'h0, vec_r};
            default:   rdata_r <= '0;
         endcase
      end else begin
         rdata_r <= '0;
      end
   end

   assign regRdata = rdata_r;
   assign memQ     = memQ_r;
   assign srOut    = sr_r;
   assign newPc    = newPc_r;
   assign pcLoad   = (st_r == S_DONE);
   assign busy     = (st_r != S_IDLE);
   assign irq      = |(stat_r & mask_r);

   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   a_copy_before_change: assert property (
      (st_r == S_CAPT) |=> srCopy_r == $past(sr_r))
      else $error("status snapshot wrong");
   a_super_entered: assert property (
      (st_r == S_CAPT) |=> sr_r[SR_S])
      else $error("supervisor bit not set");
   a_trace_cleared: assert property (
      (st_r == S_CAPT) |=> !sr_r[SR_T1] && !sr_r[SR_T0])
      else $error("trace bits not cleared");
   a_reset_mask: assert property (
      (st_r == S_CAPT && kRst_r) |=> sr_r[SR_IPM +: 3] == IPM_MAX)
      else $error("reset mask not raised");
   a_reset_noframe: assert property (
      (st_r == S_CAPT && kRst_r) |=> st_r == S_VEC && !sr_r[SR_M])
      else $error("reset pushed a frame");
   a_iack_class: assert property (
      (memQ_r.req && memQ_r.iack) |-> st_r == S_IACK && !memQ_r.wr)
      else $error("acknowledge cycle misclassified");
   a_vector_addr: assert property (
      (st_r == S_VEC && memQ_r.req) |->
      memQ_r.addr == vbase_r + (32'(vec_r) << VEC_SHIFT))
      else $error("vector address wrong");
   a_push_addr: assert property (
      (st_r == S_PUSH && memQ_r.req) |->
      memQ_r.wr && memQ_r.addr == spSel - LONG_BYTES)
      else $error("frame push address wrong");
   a_frame_status: assert property (
      (st_r == S_PUSH && memQ_r.req && lastLong) |->
      memQ_r.wdata[31:16] == srCopy_r)
      else $error("frame holds altered status");
   a_throw_clear: assert property (
      (pushing && lastLong && throw_r) |=> !sr_r[SR_M] && !onMsp_r)
      else $error("master select not cleared");
   a_pc_loaded: assert property (
      (st_r == S_VEC && ack) |=> pcLoad && newPc == $past(memRdata)
      ##1 !pcLoad)
      else $error("new program counter not loaded");
   a_trap_pending: assert property (
      insRaise |=> pend_r[P_INS])
      else $error("instruction exception lost");

   c_interrupt: cover property ((st_r == S_IACK) && ack);
   c_throwaway: cover property (pushing && lastLong && throw_r);
   c_reset: cover property ((st_r == S_CAPT) && kRst_r);
   c_bus_fault: cover property ((st_r == S_PUSH) && longFr_r && ack);
endmodule

/* pes_pkg.sv */
// shared constants and types of the exception sequencer
package pes_pkg;
   // register map, byte addresses
   localparam logic [7:0] REG_VBASE = 8'h00;
   localparam logic [7:0] REG_MSP   = 8'h04;
   localparam logic [7:0] REG_ISP   = 8'h08;
   localparam logic [7:0] REG_SR    = 8'h0C;
   localparam logic [7:0] REG_STAT  = 8'h10;
   localparam logic [7:0] REG_MASK  = 8'h14;
   localparam logic [7:0] REG_NEWPC = 8'h18;
   localparam logic [7:0] REG_VEC   = 8'h1C;
   // status register fields and reset value
   localparam int          SR_T1    = 15;
   localparam int          SR_T0    = 14;
   localparam int          SR_S     = 13;
   localparam int          SR_M     = 12;
   localparam int          SR_IPM   = 8;
   localparam logic [15:0] SR_RST   = 16'h2700;
   localparam logic [2:0]  IPM_MAX  = 3'h7;
   // interrupt status bits
   localparam int          ST_DONE  = 0;
   localparam int          ST_BERR  = 1;
   localparam int          ST_INT   = 2;
   localparam int          ST_RST   = 3;
   localparam int          ST_W     = 4;
   // pending request bits, highest priority first
   localparam int          P_RST    = 0;
   localparam int          P_BERR   = 1;
   localparam int          P_ODD    = 2;
   localparam int          P_TRC    = 3;
   localparam int          P_ILL    = 4;
   localparam int          P_PRV    = 5;
   localparam int          P_INS    = 6;
   localparam int          P_CP     = 7;
   localparam int          P_W      = 8;
   // internally generated vector numbers
   localparam logic [7:0]  VEC_RESET   = 8'h01;
   localparam logic [7:0]  VEC_BUSERR  = 8'h02;
   localparam logic [7:0]  VEC_ADDRERR = 8'h03;
   localparam logic [7:0]  VEC_ILLEGAL = 8'h04;
   localparam logic [7:0]  VEC_ZERODIV = 8'h05;
   localparam logic [7:0]  VEC_BOUNDS  = 8'h06;
   localparam logic [7:0]  VEC_CTRAP   = 8'h07;
   localparam logic [7:0]  VEC_PRIV    = 8'h08;
   localparam logic [7:0]  VEC_TRACE   = 8'h09;
   localparam logic [7:0]  VEC_SWBASE  = 8'h20;
   // vector offset and stack frames
   localparam int          VEC_SHIFT   = 2;
   localparam logic [31:0] LONG_BYTES  = 32'h0000_0004;
   localparam logic [3:0]  FMT_SHORT   = 4'h0;
   localparam logic [3:0]  FMT_THROW   = 4'h1;
   localparam logic [3:0]  FMT_FAULT   = 4'hA;
   localparam logic [1:0]  IDX_SHORT   = 2'h1;
   localparam logic [1:0]  IDX_FAULT   = 2'h3;

   typedef enum logic [5:0] {
      S_IDLE = 6'h01,
      S_CAPT = 6'h02,
      S_IACK = 6'h04,
      S_PUSH = 6'h08,
      S_VEC  = 6'h10,
      S_DONE = 6'h20
   } pes_state_e;

   typedef enum logic [2:0] {
      IK_TRAP   = 3'h0,
      IK_CTRAP  = 3'h1,
      IK_OVTRAP = 3'h2,
      IK_CPTRAP = 3'h3,
      IK_BND    = 3'h4,
      IK_BND2   = 3'h5,
      IK_DIV    = 3'h6
   } pes_ikind_e;

   typedef struct packed {
      logic       valid;
      pes_ikind_e kind;
      logic       cond;
      logic [3:0] trapNum;
   } pes_instr_s;

   typedef struct packed {
      logic        req;
      logic        wr;
      logic        iack;
      logic [31:0] addr;
      logic [31:0] wdata;
   } pes_mem_s;
endpackage

/* pes_mem_model.sv */
// memory and interrupt source model facing the exception sequencer
`timescale 1ns/10ps
module pes_mem_model
   import pes_pkg::*;
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        nrst,
   // bench control
   input  wire logic        slow,
   input  wire logic [2:0]  raiseLvl,
   input  wire logic [7:0]  iackVec,
   input  wire logic        clrLog,
   // memory side
   input  pes_mem_s         memQ,
   output logic             memAck,
   output logic      [31:0] memRdata,
   output logic      [2:0]  ipl
);
   logic [31:0] wrAddr [8];
   logic [31:0] wrData [8];
   int          wrCnt;
   logic [31:0] rdAddr;
   logic [31:0] iackAddr;
   logic [1:0]  waitCnt;

   always_ff @(posedge clk) begin
      memAck <= 1'b0;
      // idle bus never repeats stale data
      memRdata <= ~memRdata;
      if (raiseLvl != 3'h0) begin
         ipl <= raiseLvl;
      end
      if (memAck && memQ.iack) begin
         ipl <= 3'h0;
      end
      if (!nrst || clrLog) begin
         wrCnt    <= 0;
         waitCnt  <= 2'h0;
         memRdata <= 32'h0;
         if (!nrst) begin
            ipl <= 3'h0;
         end
      end else if (memQ.req && !memAck) begin
         if (slow && waitCnt != 2'h3) begin
            waitCnt <= waitCnt + 2'h1;
         end else begin
            waitCnt <= 2'h0;
            memAck  <= 1'b1;
            if (memQ.iack) begin
               memRdata <= {24'h0, iackVec};
               iackAddr <= memQ.addr;
            end else if (memQ.wr) begin
               wrAddr[wrCnt[2:0]] <= memQ.addr;
               wrData[wrCnt[2:0]] <= memQ.wdata;
               wrCnt              <= wrCnt + 1;
            end else begin
               memRdata <= memQ.addr ^ 32'h5A00_0000;
               rdAddr   <= memQ.addr;
            end
         end
      end
   end
endmodule

/* tb_top.sv */
// self-checking bench of the exception sequencer
`timescale 1ns/10ps
module tb_top
   import pes_pkg::*;
;
   logic        clk = 1'b0;
   logic        nrst = 1'b0;
   logic [7:0]  regAddr = 8'h00;
   logic [31:0] regWdata = 32'h0;
   logic        regWr = 1'b0;
   logic        regRd = 1'b0;
   logic [31:0] regRdata;
   logic        rstExc = 1'b0;
   logic        busErr = 1'b0;
   logic [31:0] faultAddr = 32'h0012_3456;
   logic        oddFetch = 1'b0;
   logic        traceReq = 1'b0;
   logic        illegalOp = 1'b0;
   logic        privViol = 1'b0;
   logic [2:0]  ipl;
   pes_instr_s  instrExc = '0;
   logic        cpExc = 1'b0;
   logic [7:0]  cpVec = 8'h77;
   logic [31:0] curPc = 32'h0000_2222;
   pes_mem_s    memQ;
   logic        memAck;
   logic [31:0] memRdata;
   logic [15:0] srOut;
   logic        pcLoad;
   logic [31:0] newPc;
   logic        busy;
   logic        irq;
   logic        slow = 1'b0;
   logic [2:0]  raiseLvl = 3'h0;
   logic        clrLog = 1'b0;
   logic [31:0] rd;
   int          mismatches = 0;
   int          checks = 0;

   always #12.5 clk = ~clk;

   pes_sequencer DUT (.clk(clk), .nrst(nrst), .regAddr(regAddr),
      .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
      .regRdata(regRdata), .rstExc(rstExc), .busErr(busErr),
      .faultAddr(faultAddr), .oddFetch(oddFetch), .traceReq(traceReq),
      .illegalOp(illegalOp), .privViol(privViol), .ipl(ipl),
      .instrExc(instrExc), .cpExc(cpExc), .cpVec(cpVec), .curPc(curPc),
      .memQ(memQ), .memAck(memAck), .memRdata(memRdata), .srOut(srOut),
      .pcLoad(pcLoad), .newPc(newPc), .busy(busy), .irq(irq));

   pes_mem_model partner (.clk(clk), .nrst(nrst), .slow(slow),
      .raiseLvl(raiseLvl), .iackVec(8'h40), .clrLog(clrLog),
      .memQ(memQ), .memAck(memAck), .memRdata(memRdata), .ipl(ipl));

   task automatic chk(input string what, input logic [31:0] exp,
                      input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      regAddr  <= a;
      regWdata <= d;
      regWr    <= 1'b1;
      @(posedge clk);
      regWr <= 1'b0;
   endtask

   task automatic reg_rd(input logic [7:0] a);
      @(posedge clk);
      regAddr <= a;
      regRd   <= 1'b1;
      @(posedge clk);
      regRd <= 1'b0;
      #1;
      rd = regRdata;
   endtask

   task automatic prep(input logic [15:0] sr);
      reg_wr(REG_VBASE, 32'h0000_1000);
      reg_wr(REG_ISP, 32'h0000_8000);
      reg_wr(REG_MSP, 32'h0000_6000);
      reg_wr(REG_SR, {16'h0, sr});
      reg_wr(REG_MASK, 32'h1);
      reg_rd(REG_STAT);
      @(posedge clk);
      clrLog <= 1'b1;
      @(posedge clk);
      clrLog <= 1'b0;
   endtask

   task automatic wait_pc();
      int n;
      n = 0;
      while (pcLoad !== 1'b1 && n < 300) begin
         @(posedge clk);
         #1;
         n++;
      end
      chk("pcLoad", 32'h1, {31'h0, pcLoad});
      repeat (2) @(posedge clk);
      #1;
   endtask

   task automatic chk_vec(input logic [7:0] v);
      logic [31:0] a;
      a = 32'h1000 + ({24'h0, v} << 2);
      chk("vector address", a, partner.rdAddr);
      chk("new pc", a ^ 32'h5A00_0000, newPc);
      reg_rd(REG_VEC);
      chk("vector reg", {24'h0, v}, rd);
      reg_rd(REG_NEWPC);
      chk("newpc reg", a ^ 32'h5A00_0000, rd);
   endtask

   task automatic t_trace();
      prep(16'hC000);
      @(posedge clk);
      traceReq <= 1'b1;
      @(posedge clk);
      traceReq <= 1'b0;
      wait_pc();
      chk("sr", 32'h2000, {16'h0, srOut});
      chk("pushes", 32'h2, partner.wrCnt);
      chk("isp push", 32'h7FFC, partner.wrAddr[0]);
      chk("frame sr", 32'hC000, partner.wrData[1] >> 16);
      chk_vec(VEC_TRACE);
      reg_wr(REG_MASK, 32'h0);
      @(posedge clk);
      #1;
      chk("masked irq", 32'h0, {31'h0, irq});
      reg_rd(REG_STAT);
      chk("stat", 32'h1, rd);
   endtask

   task automatic t_irq();
      prep(16'h1000);
      slow <= 1'b1;
      raiseLvl <= 3'h3;
      @(posedge clk);
      raiseLvl <= 3'h0;
      wait_pc();
      chk("iack address", 32'h3, partner.iackAddr);
      chk("sr", 32'h2300, {16'h0, srOut});
      chk("pushes", 32'h4, partner.wrCnt);
      chk("msp push", 32'h5FF8, partner.wrAddr[1]);
      chk("isp push", 32'h7FF8, partner.wrAddr[3]);
      chk("frame sr", 32'h1000, partner.wrData[3] >> 16);
      chk("msp fmt", 32'h1, (partner.wrData[0] >> 12) & 32'hF);
      chk("isp fmt", 32'h0, (partner.wrData[2] >> 12) & 32'hF);
      chk_vec(8'h40);
      chk("irq", 32'h1, {31'h0, irq});
      reg_rd(REG_STAT);
      chk("stat", 32'h5, rd);
      @(posedge clk);
      #1;
      chk("irq cleared", 32'h0, {31'h0, irq});
      slow <= 1'b0;
   endtask

   task automatic t_berr();
      prep(16'h3000);
      slow <= 1'b1;
      @(posedge clk);
      busErr <= 1'b1;
      @(posedge clk);
      busErr <= 1'b0;
      // lands while sequencing, must be ignored
      reg_wr(REG_ISP, 32'h0000_4000);
      wait_pc();
      chk("pushes", 32'h4, partner.wrCnt);
      chk("msp push", 32'h5FFC, partner.wrAddr[0]);
      chk("frame pc", curPc, partner.wrData[0]);
      chk("frame fault", faultAddr, partner.wrData[1]);
      chk("sr", 32'h3000, {16'h0, srOut});
      chk_vec(VEC_BUSERR);
      chk("fault fmt", 32'hA, (partner.wrData[2] >> 12) & 32'hF);
      reg_rd(REG_ISP);
      chk("isp held", 32'h8000, rd);
      reg_rd(REG_MSP);
      chk("msp after", 32'h5FF0, rd);
      slow <= 1'b0;
   endtask

   task automatic t_rstexc();
      prep(16'h1000);
      @(posedge clk);
      rstExc <= 1'b1;
      @(posedge clk);
      rstExc <= 1'b0;
      wait_pc();
      chk("pushes", 32'h0, partner.wrCnt);
      chk("sr", 32'h2700, {16'h0, srOut});
      chk_vec(VEC_RESET);
   endtask

   task automatic fire(input int i, input logic c);
      @(posedge clk);
      case (i)
         0: oddFetch <= 1'b1;
         1: illegalOp <= 1'b1;
         2: privViol <= 1'b1;
         10: cpExc <= 1'b1;
         default: instrExc <= '{1'b1, pes_ikind_e'(3'(i - 3)), c, 4'h3};
      endcase
      @(posedge clk);
      {oddFetch, illegalOp, privViol, cpExc} <= 4'h0;
      instrExc <= '0;
   endtask

   task automatic t_vectors();
      logic [7:0] ev [11];
      ev = '{8'h03, 8'h04, 8'h08, 8'h23, 8'h07, 8'h07, 8'h07, 8'h06,
             8'h06, 8'h05, 8'h77};
      for (int i = 0; i < 11; i++) begin
         prep(16'h0000);
         fire(i, 1'b1);
         wait_pc();
         chk_vec(ev[i]);
      end
      prep(16'h0000);
      fire(4, 1'b0);
      repeat (10) @(posedge clk);
      #1;
      chk("untaken busy", 32'h0, {31'h0, busy});
      chk("untaken sr", 32'h0, {16'h0, srOut});
   endtask

   task automatic test_done();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   initial begin
      #1_000_000;
      mismatches++;
      test_done();
   end

   initial begin
      repeat (8) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      #1;
      chk("reset sr", 32'h2700, {16'h0, srOut});
      chk("reset busy", 32'h0, {31'h0, busy});
      reg_rd(8'h40);
      chk("unmapped read", 32'h0, rd);
      t_trace();
      t_irq();
      t_berr();
      t_rstexc();
      t_vectors();
      test_done();
   end
endmodule
